// *** verilog/serial_flash_write_protection.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_flash_write_protection
   import flash_protect_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic data_line0_in,
   output logic data_line1_out,
   output logic data_line1_oe_out,
   input wire logic protect_pin_line2_in,
   output logic protect_pin_line2_out,
   output logic protect_pin_line2_oe_out,
   input wire logic pause_pin_line3_in,
   output logic pause_pin_line3_out,
   output logic pause_pin_line3_oe_out,
   input wire logic factory_lock_in,
   output logic op_go_out,
   output op_kind_t op_kind_out,
   output logic [ADDR_W-1:0] op_addr_out,
   output logic op_otp_out,
   output logic refused_out,
   output logic write_enable_latch_out,
   output logic [LEVEL_W-1:0] protect_level_bits_out,
   output logic top_bottom_select_out,
   output logic status_write_lock_out,
   output logic quad_mode_out,
   output logic [1:0] security_out,
   output logic otp_mode_out,
   output logic deep_sleep_out,
   output logic pin_protect_mode_out
);
   state_t state;
   logic cs_n_s, sclk_s, d0_s, wp_n_s, pause_n_s;
   logic cs_prev, sclk_prev, paused, reading, strap_taken;
   logic [2:0] bit_cnt, byte_cnt;
   logic [7:0] shift, opcode, wr0, wr1, out_shift;
   logic [ADDR_W-1:0] addr;
   logic [7:0] next_byte;
   logic cs_fall, cs_rise, sclk_rise, sclk_fall, bit_edge, frame_end, byte_end;
   logic block_protected, pin_mode, otp_row_locked;
   logic do_go, do_refuse, do_wel_set, do_wel_clr, do_status, do_cfg, do_lock, do_sleep;
   logic do_otp_enter, do_otp_exit;
   op_kind_t go_kind;

   bit_sync #(
      .WIDTH(5),
      .RESET_VAL(5'h13)
   ) u_sync (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .async_in({cs_n_in, sclk_in, data_line0_in, protect_pin_line2_in, pause_pin_line3_in}),
      .sync_out({cs_n_s, sclk_s, d0_s, wp_n_s, pause_n_s})
   );

   protect_map u_map (
      .level_in(protect_level_bits_out),
      .top_bottom_in(top_bottom_select_out),
      .block_in(addr[BLOCK_LSB +: BLOCK_W]),
      .protected_out(block_protected)
   );

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         cs_prev <= 1'b1;
         // Idle serial clock is low; a high reset value would fake a fall
         sclk_prev <= 1'b0;
      end
      else
      begin
         cs_prev <= cs_n_s;
         sclk_prev <= sclk_s;
      end
   end

   assign cs_fall = cs_prev && !cs_n_s;
   assign cs_rise = !cs_prev && cs_n_s;
   assign sclk_rise = !sclk_prev && sclk_s;
   assign sclk_fall = sclk_prev && !sclk_s;
   assign bit_edge = sclk_rise && !cs_n_s && !paused && state == ST_ACTIVE;
   assign byte_end = bit_edge && bit_cnt == BIT_LAST;
   assign frame_end = cs_rise && state == ST_ACTIVE;
   assign next_byte = {shift[6:0], d0_s};
   assign pin_mode = status_write_lock_out && !wp_n_s && !quad_mode_out;
   assign otp_row_locked = addr[OTP_ROW_BIT] ? security_out[SEC_FACTORY_BIT] : security_out[SEC_CUSTOMER_BIT];

   // pause only outside quad mode, changes while clock is low
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         paused <= 1'b0;
      else if (quad_mode_out || cs_n_s)
         paused <= 1'b0;
      else if (!sclk_s)
         paused <= !pause_n_s;
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         state <= ST_STANDBY;
      else
      begin
         case (state)
            ST_STANDBY:
               if (cs_fall)
                  state <= ST_ACTIVE;
            ST_ACTIVE:
               if (cs_rise)
                  state <= do_sleep ? ST_SLEEP : ST_STANDBY;
            // only a chip select pulse wakes
            ST_SLEEP:
               if (cs_rise)
                  state <= ST_STANDBY;
            default:
               state <= ST_STANDBY;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         shift <= '0;
         bit_cnt <= '0;
         byte_cnt <= '0;
         opcode <= '0;
         wr0 <= '0;
         wr1 <= '0;
         addr <= '0;
      end
      else if (cs_fall)
      begin
         bit_cnt <= '0;
         byte_cnt <= '0;
         opcode <= '0;
      end
      else if (bit_edge)
      begin
         shift <= next_byte;
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == BIT_LAST)
         begin
            if (byte_cnt != BYTE_CNT_MAX)
               byte_cnt <= byte_cnt + 3'h1;
            if (byte_cnt == 3'h0)
               opcode <= next_byte;
            if (byte_cnt == 3'h1)
               wr0 <= next_byte;
            if (byte_cnt == 3'h2)
               wr1 <= next_byte;
            if (byte_cnt >= 3'h1 && byte_cnt < LEN_ADDR)
               addr <= {addr[ADDR_W-9:0], next_byte};
         end
      end
   end

   // Decision taken once, at the frame's end
   always_comb
   begin
      do_go = 1'b0;
      do_refuse = 1'b0;
      do_wel_set = 1'b0;
      do_wel_clr = 1'b0;
      do_status = 1'b0;
      do_cfg = 1'b0;
      do_lock = 1'b0;
      do_sleep = 1'b0;
      do_otp_enter = 1'b0;
      do_otp_exit = 1'b0;
      go_kind = OP_NONE;
      if (frame_end && bit_cnt == 3'h0)
      begin
         case (opcode)
            CMD_SET_WRITE_LATCH:
               do_wel_set = byte_cnt == LEN_OPCODE;
            CMD_CLEAR_WRITE_LATCH:
               do_wel_clr = byte_cnt == LEN_OPCODE;
            CMD_DEEP_SLEEP:
               do_sleep = byte_cnt == LEN_OPCODE;
            CMD_ENTER_OTP:
               do_otp_enter = byte_cnt == LEN_OPCODE;
            CMD_EXIT_OTP:
               do_otp_exit = byte_cnt == LEN_OPCODE;
            CMD_WRITE_STATUS:
            begin
               if ((byte_cnt == LEN_WRSR_SHORT || byte_cnt == LEN_WRSR_LONG) && write_enable_latch_out && !pin_mode)
               begin
                  do_status = 1'b1;
                  do_cfg = byte_cnt == LEN_WRSR_LONG;
                  do_wel_clr = 1'b1;
               end
               else
                  do_refuse = 1'b1;
            end
            CMD_WRITE_SECURITY:
            begin
               if (byte_cnt == LEN_OPCODE && write_enable_latch_out)
               begin
                  do_lock = 1'b1;
                  do_wel_clr = 1'b1;
               end
               else
                  do_refuse = 1'b1;
            end
            CMD_PROGRAM, CMD_SECTOR_ERASE, CMD_BLOCK32_ERASE, CMD_BLOCK64_ERASE, CMD_CHIP_ERASE:
            begin
               case (opcode)
                  CMD_PROGRAM: go_kind = OP_PROGRAM;
                  CMD_SECTOR_ERASE: go_kind = OP_SECTOR;
                  CMD_BLOCK32_ERASE: go_kind = OP_BLOCK32;
                  CMD_BLOCK64_ERASE: go_kind = OP_BLOCK64;
                  default: go_kind = OP_CHIP;
               endcase
               do_go = write_enable_latch_out;
               if (go_kind == OP_PROGRAM)
                  do_go = do_go && byte_cnt >= LEN_PROGRAM_MIN;
               else if (go_kind == OP_CHIP)
                  do_go = do_go && byte_cnt == LEN_OPCODE;
               else
                  do_go = do_go && byte_cnt == LEN_ADDR;
               // OTP mode: only programs, into unlocked rows
               if (otp_mode_out)
                  do_go = do_go && go_kind == OP_PROGRAM && !otp_row_locked;
               else if (go_kind == OP_CHIP)
                  do_go = do_go && protect_level_bits_out == LVL_NONE;
               else
                  do_go = do_go && !block_protected;
               do_refuse = !do_go;
               do_wel_clr = do_go;
            end
            default:
               do_go = 1'b0;
         endcase
      end
      else if (frame_end && byte_cnt != 3'h0)
         do_refuse = 1'b1;
   end

   // refused ops keep op_go_out low and pulse refused_out; no busy state exists
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         op_go_out <= 1'b0;
         op_kind_out <= OP_NONE;
         op_addr_out <= '0;
         op_otp_out <= 1'b0;
         refused_out <= 1'b0;
      end
      else
      begin
         op_go_out <= do_go;
         refused_out <= do_refuse;
         if (do_go)
         begin
            op_kind_out <= go_kind;
            op_addr_out <= addr;
            op_otp_out <= otp_mode_out;
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         write_enable_latch_out <= 1'b0;
      else if (do_wel_set)
         write_enable_latch_out <= 1'b1;
      else if (do_wel_clr)
         write_enable_latch_out <= 1'b0;
   end

   // Nonvolatile in silicon; here they restart cleared
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         protect_level_bits_out <= LVL_NONE;
         status_write_lock_out <= 1'b0;
         quad_mode_out <= 1'b0;
         top_bottom_select_out <= 1'b0;
         otp_mode_out <= 1'b0;
         deep_sleep_out <= 1'b0;
         pin_protect_mode_out <= 1'b0;
      end
      else
      begin
         pin_protect_mode_out <= pin_mode;
         deep_sleep_out <= state == ST_SLEEP || (frame_end && do_sleep);
         if (do_status)
         begin
            protect_level_bits_out <= wr0[STAT_LEVEL_LSB +: LEVEL_W];
            status_write_lock_out <= wr0[STAT_LOCK_BIT];
            quad_mode_out <= wr0[STAT_QUAD_BIT];
         end
         // Top/bottom is one-time: it can be set, never cleared
         if (do_cfg && wr1[CFG_TB_BIT])
            top_bottom_select_out <= 1'b1;
         if (do_otp_enter)
            otp_mode_out <= 1'b1;
         else if (do_otp_exit)
            otp_mode_out <= 1'b0;
      end
   end

   // factory lock taken as a strap after reset release
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         security_out <= 2'h0;
         strap_taken <= 1'b0;
      end
      else
      begin
         if (!strap_taken)
         begin
            security_out[SEC_FACTORY_BIT] <= factory_lock_in;
            strap_taken <= 1'b1;
         end
         if (do_lock)
            security_out[SEC_CUSTOMER_BIT] <= 1'b1;
      end
   end

   // output shifts on the falling clock
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         reading <= 1'b0;
         out_shift <= '0;
         data_line1_out <= 1'b0;
         data_line1_oe_out <= 1'b0;
      end
      else
      begin
         data_line1_oe_out <= reading && !cs_n_s && !paused;
         if (cs_fall || cs_rise)
            reading <= 1'b0;
         else if (byte_end && byte_cnt == 3'h0)
         begin
            reading <= next_byte == CMD_READ_STATUS || next_byte == CMD_READ_SECURITY;
            if (next_byte == CMD_READ_SECURITY)
               out_shift <= {6'h00, security_out};
            else
            begin
               out_shift <= {status_write_lock_out, quad_mode_out, protect_level_bits_out, write_enable_latch_out, 1'b0};
            end
         end
         else if (sclk_fall && reading && !paused)
         begin
            data_line1_out <= out_shift[7];
            out_shift <= {out_shift[6:0], out_shift[7]};
         end
      end
   end

   // quad data path not built: lines 2 and 3 stay inputs
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         protect_pin_line2_out <= 1'b0;
         protect_pin_line2_oe_out <= 1'b0;
         pause_pin_line3_out <= 1'b0;
         pause_pin_line3_oe_out <= 1'b0;
      end
      else
      begin
         protect_pin_line2_out <= 1'b0;
         protect_pin_line2_oe_out <= 1'b0;
         pause_pin_line3_out <= 1'b0;
         pause_pin_line3_oe_out <= 1'b0;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   standby_after_reset_a: assert property ($rose(reset_n_in) |-> state == ST_STANDBY)
      else $error("not in standby after reset");
   partial_byte_reject_a: assert property (frame_end && bit_cnt != 3'h0 |=> !op_go_out)
      else $error("partial byte frame executed");
   wel_needed_a: assert property (op_go_out |-> $past(write_enable_latch_out) && !write_enable_latch_out)
      else $error("operation without write latch");
   sleep_ignores_cmds_a: assert property (state == ST_SLEEP |=> !op_go_out && $stable(protect_level_bits_out))
      else $error("command acted on in deep sleep");
   block_protect_go_a: assert property (op_go_out && !op_otp_out && op_kind_out != OP_CHIP |-> !block_protected)
      else $error("protected block operated on");
   chip_erase_gate_a: assert property (op_go_out && op_kind_out == OP_CHIP |-> protect_level_bits_out == LVL_NONE)
      else $error("chip erase with protect level set");
   pin_lock_hold_a: assert property (pin_mode |=> $stable(protect_level_bits_out) && $stable(status_write_lock_out))
      else $error("status changed under pin protection");
   quad_no_pin_a: assert property (quad_mode_out |-> !pin_mode ##1 !pin_protect_mode_out)
      else $error("pin protection active in quad mode");
   otp_lock_hold_a: assert property (op_go_out && op_otp_out |-> !(op_addr_out[OTP_ROW_BIT] ? security_out[SEC_FACTORY_BIT] : security_out[SEC_CUSTOMER_BIT]))
      else $error("locked OTP row changed");
   otp_no_array_a: assert property (op_go_out && otp_mode_out |-> op_otp_out && op_kind_out == OP_PROGRAM)
      else $error("array access in OTP mode");

   program_seen_c: cover property (op_go_out && op_kind_out == OP_PROGRAM && !op_otp_out);
   otp_program_c: cover property (op_go_out && op_otp_out);
   refused_c: cover property (refused_out && write_enable_latch_out);
   sleep_wake_c: cover property (state == ST_SLEEP ##[1:200] state == ST_STANDBY);
endmodule
`default_nettype wire

// *** verilog/flash_protect_pkg.sv ***
package flash_protect_pkg;
   localparam int ADDR_W = 24;
   localparam int BYTE_W = 8;
   localparam int BLOCK_W = 5;
   localparam int BLOCK_LSB = 16;
   localparam int LEVEL_W = 4;
   localparam int OTP_ROW_BIT = 9;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
   // Frame lengths in bytes, opcode included
   localparam logic [2:0] LEN_OPCODE = 3'h1;
   localparam logic [2:0] LEN_WRSR_SHORT = 3'h2;
   localparam logic [2:0] LEN_WRSR_LONG = 3'h3;
   localparam logic [2:0] LEN_ADDR = 3'h4;
   localparam logic [2:0] LEN_PROGRAM_MIN = 3'h5;
   // Opcodes
   localparam logic [7:0] CMD_SET_WRITE_LATCH = 8'h06;
   localparam logic [7:0] CMD_CLEAR_WRITE_LATCH = 8'h04;
   localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
   localparam logic [7:0] CMD_READ_STATUS = 8'h05;
   localparam logic [7:0] CMD_READ_SECURITY = 8'h2B;
   localparam logic [7:0] CMD_WRITE_SECURITY = 8'h2F;
   localparam logic [7:0] CMD_PROGRAM = 8'h02;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] CMD_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] CMD_BLOCK64_ERASE = 8'hD8;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h60;
   localparam logic [7:0] CMD_DEEP_SLEEP = 8'hB9;
   localparam logic [7:0] CMD_ENTER_OTP = 8'hB1;
   localparam logic [7:0] CMD_EXIT_OTP = 8'hC1;
   // Status byte layout, then config and security bit positions
   localparam int STAT_WEL_BIT = 1;
   localparam int STAT_LEVEL_LSB = 2;
   localparam int STAT_QUAD_BIT = 6;
   localparam int STAT_LOCK_BIT = 7;
   localparam int CFG_TB_BIT = 3;
   localparam int SEC_FACTORY_BIT = 0;
   localparam int SEC_CUSTOMER_BIT = 1;
   // Protect level codes
   localparam logic [3:0] LVL_NONE = 4'h0;
   localparam logic [3:0] LVL_LOW_FIRST = 4'h1;
   localparam logic [3:0] LVL_LOW_LAST = 4'h5;
   localparam logic [3:0] LVL_HIGH_FIRST = 4'hA;
   localparam logic [3:0] LVL_HIGH_LAST = 4'hE;

   typedef enum logic [2:0] {
      ST_STANDBY = 3'h1,
      ST_ACTIVE = 3'h2,
      ST_SLEEP = 3'h4
   } state_t;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_PROGRAM = 3'h1,
      OP_SECTOR = 3'h2,
      OP_BLOCK32 = 3'h3,
      OP_BLOCK64 = 3'h4,
      OP_CHIP = 3'h5
   } op_kind_t;
endpackage

// *** verilog/bit_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge clk_in or negedge reset_n_in)
         begin
            if (!reset_n_in)
            begin
               stage1[i] <= RESET_VAL[i];
               sync_out[i] <= RESET_VAL[i];
            end
            else
            begin
               stage1[i] <= async_in[i];
               sync_out[i] <= stage1[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// *** verilog/protect_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module protect_map
   import flash_protect_pkg::*;
#(
   parameter int BW = BLOCK_W
) (
   input wire logic [LEVEL_W-1:0] level_in,
   input wire logic top_bottom_in,
   input wire logic [BW-1:0] block_in,
   output logic protected_out
);
   // Region of span blocks at the low or high end of the array
   function automatic logic in_region(input logic [BW:0] span, input logic low_end, input logic [BW-1:0] blk);
      logic [BW:0] b;
      b = {1'b0, blk};
      in_region = low_end ? (b < span) : (b >= ((BW+1)'(1 << BW) - span));
   endfunction

   logic [BW:0] span;

   always_comb
   begin
      span = '0;
      protected_out = 1'b1;
      if (level_in == LVL_NONE)
         protected_out = 1'b0;
      else if (level_in >= LVL_LOW_FIRST && level_in <= LVL_LOW_LAST)
      begin
         span = (BW+1)'(1) << (level_in - LVL_LOW_FIRST);
         protected_out = in_region(span, top_bottom_in, block_in);
      end
      else if (level_in >= LVL_HIGH_FIRST && level_in <= LVL_HIGH_LAST)
      begin
         // A shrinking region on the same side stays writable; its complement is protected
         span = (BW+1)'(1 << (BW - 1)) >> (level_in - LVL_HIGH_FIRST);
         protected_out = !in_region(span, top_bottom_in, block_in);
      end
   end
endmodule
`default_nettype wire

// *** sim/spi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input wire logic clk_in,
   output logic cs_n_out,
   output logic sclk_out,
   output logic mosi_out,
   input wire logic miso_in,
   output logic [7:0] rx_out
);
   initial
   begin
      rx_out = 8'h00;
      cs_n_out = 1'h1;
      sclk_out = 1'h0;
      mosi_out = 1'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic frame(input logic [63:0] bits, input int n);
      cs_n_out <= 1'h0;
      tick(4);
      for (int i = n - 1; i >= 0; i--)
      begin
         mosi_out <= bits[i];
         tick(3);
         // reply bit taken as the clock rises
         rx_out <= {rx_out[6:0], miso_in};
         sclk_out <= 1'h1;
         tick(4);
         sclk_out <= 1'h0;
         tick(1);
      end
      // Released line flips so a stale bit never looks valid
      cs_n_out <= 1'h1;
      mosi_out <= ~mosi_out;
      tick(12);
   endtask
endmodule
`default_nettype wire

// *** sim/serial_flash_write_protection_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_flash_write_protection_tb import flash_protect_pkg::*;;
   logic clk_in, reset_n_in, cs_n_in, sclk_in, data_line0_in, protect_pin_line2_in, pause_pin_line3_in;
   logic factory_lock_in, data_line1_out, data_line1_oe_out, protect_pin_line2_out, protect_pin_line2_oe_out;
   logic pause_pin_line3_out, pause_pin_line3_oe_out, op_go_out, op_otp_out, refused_out, write_enable_latch_out;
   logic top_bottom_select_out, status_write_lock_out, quad_mode_out, otp_mode_out, deep_sleep_out;
   logic pin_protect_mode_out;
   logic seen_go = 1'h0;
   logic seen_ref = 1'h0;
   op_kind_t op_kind_out;
   logic [ADDR_W-1:0] op_addr_out;
   logic [LEVEL_W-1:0] protect_level_bits_out;
   logic [1:0] security_out;
   logic [7:0] rx;
   int fail_count = 0;
   int check_count = 0;
   int unsigned seed = 84683;
   logic [7:0] ops [3] = '{CMD_SECTOR_ERASE, CMD_BLOCK32_ERASE, CMD_BLOCK64_ERASE};
   op_kind_t kinds [3] = '{OP_SECTOR, OP_BLOCK32, OP_BLOCK64};

   serial_flash_write_protection i_dut (.clk_in, .reset_n_in, .cs_n_in, .sclk_in, .data_line0_in, .data_line1_out,
      .data_line1_oe_out, .protect_pin_line2_in, .protect_pin_line2_out, .protect_pin_line2_oe_out,
      .pause_pin_line3_in, .pause_pin_line3_out, .pause_pin_line3_oe_out, .factory_lock_in, .op_go_out,
      .op_kind_out, .op_addr_out, .op_otp_out, .refused_out, .write_enable_latch_out, .protect_level_bits_out,
      .top_bottom_select_out, .status_write_lock_out, .quad_mode_out, .security_out, .otp_mode_out,
      .deep_sleep_out, .pin_protect_mode_out);
   spi_host_model i_host (.clk_in(clk_in), .cs_n_out(cs_n_in), .sclk_out(sclk_in), .mosi_out(data_line0_in),
      .miso_in(data_line1_out), .rx_out(rx));

   initial
   begin
      clk_in = 1'h0;
      forever #50 clk_in = ~clk_in;
   end
   always @(posedge clk_in)
   begin
      if (op_go_out === 1'h1)
         seen_go <= 1'h1;
      if (refused_out === 1'h1)
         seen_ref <= 1'h1;
   end

   function automatic int unsigned rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic prot(int lv, int t, int b);
      int n;
      if (lv == 0)
         return 1'h0;
      if (lv <= 5)
         return (t == 0) ? (b >= 32 - (1 << (lv - 1))) : (b < (1 << (lv - 1)));
      if (lv < 10 || lv == 15)
         return 1'h1;
      n = 32 - (1 << (14 - lv));
      return (t == 0) ? (b < n) : (b >= 32 - n);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cmd(input logic [63:0] b, input int n, input logic eg, input logic er);
      @(posedge clk_in);
      seen_go <= 1'h0;
      seen_ref <= 1'h0;
      i_host.frame(b, n);
      check(seen_go, eg);
      check(seen_ref, er);
   endtask
   task automatic wcmd(input logic [63:0] b, input int n, input logic eg, input logic er);
      cmd(CMD_SET_WRITE_LATCH, 8, 1'h0, 1'h0);
      cmd(b, n, eg, er);
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      logic [23:0] a;
      logic p;
      int k;
      reset_n_in = 1'h0;
      factory_lock_in = 1'h1;
      pause_pin_line3_in = 1'h1;
      protect_pin_line2_in = 1'h1;
      repeat (20) @(posedge clk_in);
      reset_n_in <= 1'h1;
      repeat (6) @(posedge clk_in);
      check({write_enable_latch_out, protect_level_bits_out, otp_mode_out, deep_sleep_out}, 32'h0);
      check(security_out, 32'h1);
      check({protect_pin_line2_out, protect_pin_line2_oe_out, pause_pin_line3_out, pause_pin_line3_oe_out}, 32'h0);
      cmd({CMD_PROGRAM, 24'h012345, 8'hA5}, 40, 1'h0, 1'h1);
      wcmd({CMD_PROGRAM, 24'h012345, 8'hA5}, 40, 1'h1, 1'h0);
      check({op_kind_out, op_addr_out, write_enable_latch_out}, {OP_PROGRAM, 24'h012345, 1'h0});
      wcmd({CMD_PROGRAM, 24'h012345, 8'hA5, 4'hF}, 44, 1'h0, 1'h1);
      check(write_enable_latch_out, 32'h1);
      for (int t = 0; t < 2; t++)
      begin
         for (int lv = 0; lv < 16; lv++)
         begin
            wcmd({CMD_WRITE_STATUS, 2'h0, lv[3:0], 2'h0, 4'h0, t[0], 3'h0}, 24, 1'h0, 1'h0);
            check({top_bottom_select_out, protect_level_bits_out}, {t[0], lv[3:0]});
            k = rnd() % 3;
            a = {3'h0, 21'(rnd())};
            p = prot(lv, t, int'(a[20:16]));
            wcmd({ops[k], a}, 32, !p, p);
            if (!p)
               check(op_kind_out, kinds[k]);
            wcmd(CMD_CHIP_ERASE, 8, lv == 0, lv != 0);
         end
      end
      wcmd({CMD_WRITE_STATUS, 8'h80, 8'h08}, 24, 1'h0, 1'h0);
      protect_pin_line2_in <= 1'h0;
      repeat (6) @(posedge clk_in);
      check(pin_protect_mode_out, 32'h1);
      cmd({CMD_READ_STATUS, 8'h00}, 16, 1'h0, 1'h0);
      check(rx, 32'h80);
      wcmd({CMD_WRITE_STATUS, 8'h8C, 8'h08}, 24, 1'h0, 1'h1);
      check(protect_level_bits_out, 32'h0);
      protect_pin_line2_in <= 1'h1;
      wcmd({CMD_WRITE_STATUS, 8'hC0, 8'h08}, 24, 1'h0, 1'h0);
      protect_pin_line2_in <= 1'h0;
      repeat (6) @(posedge clk_in);
      check({pin_protect_mode_out, quad_mode_out}, 32'h1);
      wcmd({CMD_WRITE_STATUS, 8'h00, 8'h08}, 24, 1'h0, 1'h0);
      protect_pin_line2_in <= 1'h1;
      cmd(CMD_ENTER_OTP, 8, 1'h0, 1'h0);
      check(otp_mode_out, 32'h1);
      wcmd({CMD_SECTOR_ERASE, 24'h000000}, 32, 1'h0, 1'h1);
      wcmd({CMD_PROGRAM, 24'h000010, 8'h5A}, 40, 1'h1, 1'h0);
      check(op_otp_out, 32'h1);
      wcmd({CMD_PROGRAM, 24'h000210, 8'h5A}, 40, 1'h0, 1'h1);
      cmd(CMD_EXIT_OTP, 8, 1'h0, 1'h0);
      wcmd(CMD_WRITE_SECURITY, 8, 1'h0, 1'h0);
      check({security_out, otp_mode_out}, 32'h6);
      cmd(CMD_ENTER_OTP, 8, 1'h0, 1'h0);
      wcmd({CMD_PROGRAM, 24'h000010, 8'h5A}, 40, 1'h0, 1'h1);
      cmd(CMD_EXIT_OTP, 8, 1'h0, 1'h0);
      cmd(CMD_CLEAR_WRITE_LATCH, 8, 1'h0, 1'h0);
      cmd(CMD_DEEP_SLEEP, 8, 1'h0, 1'h0);
      check({deep_sleep_out, write_enable_latch_out}, 32'h2);
      cmd(CMD_SET_WRITE_LATCH, 8, 1'h0, 1'h0);
      check({deep_sleep_out, write_enable_latch_out}, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
